// [shared/cfs_pkg.sv]
// cyclic frame value sniffer: shared constants, types and register map
// assumes a 100 MHz system clock and a same-clock bus receiver upstream
package cfs_pkg;
  // indication slots and frame limits
  localparam int NSLOT = 10;
  localparam int IDX_W = 8; // byte index within a frame
  localparam int REC_BYTES = 5; // float_with_status_record length
  localparam int STS_POS = 4; // status byte follows the four float bytes
  // receiver line rate, handled by the physical layer ahead of this block
  localparam int BIT_RATE_BPS = 31250;
  // register map (byte addresses), one word per slot in each bank
  localparam int RA_W = 8;
  localparam logic [1:0] BANK_CFG = 2'h0; // 0x00 + 4*slot
  localparam logic [1:0] BANK_VAL = 2'h1; // 0x40 + 4*slot
  localparam logic [1:0] BANK_STS = 2'h2; // 0x80 + 4*slot
  localparam int BANK_LSB = 6;
  localparam int SLOT_LSB = 2;
  // status word fields
  localparam int ST_VALID_BIT = 8;
  localparam int ST_FLAG_BIT = 9;
  localparam int QUAL_LSB = 6; // quality bits of the status byte
  localparam logic [1:0] QUAL_BAD = 2'h0;
  localparam logic [1:0] QUAL_UNC = 2'h1;
  // display dwell per half of a slot's turn (label, then status)
  localparam int CLK_HZ = 100_000_000;
  localparam int DWELL_MS = 2000;
  localparam int DWELL_CYC = (CLK_HZ / 1000) * DWELL_MS;
  localparam int FIFO_DEPTH = 8;
  // data types of an indication
  typedef enum logic [2:0] {
    T_FWS = 3'h0, T_FLT = 3'h1, T_U8 = 3'h2, T_U16 = 3'h3,
    T_U32 = 3'h4, T_S8 = 3'h5, T_S16 = 3'h6, T_S32 = 3'h7
  } cfs_type_e;
  // byte order handling
  typedef enum logic [1:0] {
    SW_NONE = 2'h0, SW_BYTE = 2'h1, SW_NIB = 2'h2, SW_RSV = 2'h3
  } cfs_swap_e;
  // slot configuration word, low bits of the config register
  typedef struct packed {
    cfs_swap_e swap;
    logic en;
    cfs_type_e dtype;
    logic [6:0] saddr;
    logic [7:0] off;
  } cfs_cfg_s;
  localparam int CFG_W = $bits(cfs_cfg_s);
  // one captured data byte from the receiver
  typedef struct packed {
    logic first; // first data byte of a cyclic frame
    logic last; // last data byte of the frame
    logic err; // frame check failed, valid with last
    logic [6:0] src; // slave address the frame belongs to
    logic [7:0] data;
  } cfs_rx_s;
  localparam int RX_W = $bits(cfs_rx_s);
endpackage

// [core/cfs_sniffer.sv]
// cyclic frame value sniffer: byte FIFO and the listening core
// assumes captured frame bytes come from a receiver on SYS_CLK
//
// Contract
// - extraction starts at offset from first byte
// - record is four float bytes, one status
// - offsets count bytes from zero
// - never transmits, only listens
// - select values by slot slave address
// - optional byte and nibble swap
// - ten independent indication slots
// - receiver fixed rate voltage mode
// - decode the eight documented data types
// - flag bad or uncertain status, alternating
// - display skips disabled slots
`timescale 1ns/1ps
`default_nettype none

module cfs_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  initial if (DEPTH < 2) $error("fifo depth below two");
  logic [W-1:0] mem [DEPTH]; // storage
  logic [PW-1:0] wr, rd, next_wr, next_rd;
  logic [CW-1:0] cnt, next_cnt;
  logic push, pop;

  // pointer and occupancy update; ready and valid are registered flags
  always_comb
  begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr = push ? ((wr == PW'(DEPTH - 1)) ? '0 : wr + 1'b1) : wr;
    next_rd = pop ? ((rd == PW'(DEPTH - 1)) ? '0 : rd + 1'b1) : rd;
    next_cnt = cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr <= '0;
      rd <= '0;
      cnt <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      wr <= next_wr;
      rd <= next_rd;
      cnt <= next_cnt;
      in_ready <= (next_cnt != CW'(DEPTH)); // honest full
      out_valid <= (next_cnt != '0); // honest empty
    end
  end

  // data storage, no reset needed
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr] <= in_data;
  end

  assign out_data = mem[rd];
endmodule // cfs_fifo

module cfs_sniffer #(
  parameter int NSLOT = cfs_pkg::NSLOT,
  parameter int DWELL = cfs_pkg::DWELL_CYC,
  parameter int FDEPTH = cfs_pkg::FIFO_DEPTH
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [cfs_pkg::RA_W-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic RX_VALID,
  input wire cfs_pkg::cfs_rx_s RX_BYTE,
  output logic RX_READY,
  output logic BUS_TX_OE_N,
  output logic [3:0] DISP_SLOT,
  output logic [31:0] DISP_VALUE,
  output cfs_pkg::cfs_type_e DISP_TYPE,
  output logic [7:0] DISP_STATUS,
  output logic DISP_VALID,
  output logic DISP_STATUS_ON,
  output logic DISP_NONE
);
  initial if (NSLOT < 1 || NSLOT > 16 || DWELL < 1) $error("bad sniffer parameters");
  typedef enum logic [0:0] {ST_RUN = 1'b0, ST_COMMIT = 1'b1} cfs_state_e;

  cfs_pkg::cfs_cfg_s cfg [NSLOT], next_cfg [NSLOT]; // slot settings
  logic [31:0] val [NSLOT], next_val [NSLOT]; // decoded values
  logic [7:0] sts [NSLOT], next_sts [NSLOT]; // status bytes
  logic [NSLOT-1:0] vld, next_vld, flg, next_flg; // value held, bad flag
  logic [39:0] shd [NSLOT], next_shd [NSLOT]; // bytes caught this frame
  cfs_state_e state, next_state;
  logic [cfs_pkg::IDX_W:0] idx, next_idx; // next byte index in frame
  logic [6:0] fsrc, next_fsrc; // frame source address
  logic ferr, next_ferr; // frame rejected
  logic [31:0] rdata, next_rdata;
  logic q_valid, q_ready;
  cfs_pkg::cfs_rx_s q;
  logic [3:0] dslot, next_dslot;
  logic [31:0] tmr, next_tmr;
  logic alt, next_alt;
  logic [NSLOT-1:0] en_mask;

  // byte buffer between receiver and extraction; stalls during commit
  cfs_fifo #(.W(cfs_pkg::RX_W), .DEPTH(FDEPTH)) u_fifo (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .in_valid(RX_VALID),
    .in_data(RX_BYTE),
    .in_ready(RX_READY),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q)
  );

  // bytes a type occupies in the frame
  function automatic logic [3:0] type_len(input cfs_pkg::cfs_type_e t);
    case (t)
      cfs_pkg::T_FWS: type_len = 4'(cfs_pkg::REC_BYTES);
      cfs_pkg::T_U8, cfs_pkg::T_S8: type_len = 4'h1;
      cfs_pkg::T_U16, cfs_pkg::T_S16: type_len = 4'h2;
      default: type_len = 4'h4;
    endcase
  endfunction

  // assemble, swap and extend captured bytes; byte 0 sits in b[39:32]
  function automatic logic [31:0] decode(input logic [39:0] b,
      input cfs_pkg::cfs_type_e t, input cfs_pkg::cfs_swap_e s);
    logic [31:0] r;
    logic [3:0] n;
    r = 32'h0;
    n = type_len(t);
    if (n == 4'h1)
      r = {24'h0, b[39:32]};
    else if (n == 4'h2)
      r = (s != cfs_pkg::SW_NONE) ? {16'h0, b[31:24], b[39:32]} : {16'h0, b[39:24]};
    else
      r = (s != cfs_pkg::SW_NONE) ? {b[15:8], b[23:16], b[31:24], b[39:32]} : b[39:8];
    if (s == cfs_pkg::SW_NIB)
      for (int k = 0; k < 4; k++)
        r[k*8 +: 8] = {r[k*8 +: 4], r[k*8+4 +: 4]};
    // signed types extend their sign bit
    case (t)
      cfs_pkg::T_S8: r = {{24{r[7]}}, r[7:0]};
      cfs_pkg::T_S16: r = {{16{r[15]}}, r[15:0]};
      default: r = r;
    endcase
    decode = r;
  endfunction

  // register file, frame capture and commit
  always_comb
  begin
    logic [cfs_pkg::IDX_W:0] bi;
    logic [cfs_pkg::IDX_W:0] rel;
    logic [cfs_pkg::IDX_W:0] fend;
    logic [3:0] si;
    bi = '0;
    rel = '0;
    fend = '0;
    si = REG_ADDR[cfs_pkg::SLOT_LSB +: 4];
    next_state = state;
    next_idx = idx;
    next_fsrc = fsrc;
    next_ferr = ferr;
    next_vld = vld;
    next_flg = flg;
    next_rdata = 32'h0;
    q_ready = (state == ST_RUN);
    for (int i = 0; i < NSLOT; i++)
    begin
      next_cfg[i] = cfg[i];
      next_val[i] = val[i];
      next_sts[i] = sts[i];
      next_shd[i] = shd[i];
    end
    // software writes slot settings
    if (REG_WR && REG_ADDR[1:0] == 2'h0 && 32'(si) < NSLOT
        && REG_ADDR[cfs_pkg::BANK_LSB +: 2] == cfs_pkg::BANK_CFG)
      next_cfg[si] = cfs_pkg::cfs_cfg_s'(REG_WDATA[cfs_pkg::CFG_W-1:0]);
    // read data appear in the next cycle; unmapped reads give zero
    if (REG_RD && REG_ADDR[1:0] == 2'h0 && 32'(si) < NSLOT)
    begin
      case (REG_ADDR[cfs_pkg::BANK_LSB +: 2])
        cfs_pkg::BANK_CFG: next_rdata = 32'(cfg[si]);
        cfs_pkg::BANK_VAL: next_rdata = val[si];
        cfs_pkg::BANK_STS: next_rdata = {22'h0, flg[si], vld[si], sts[si]};
        default: next_rdata = 32'h0;
      endcase
    end
    case (state)
      ST_RUN:
      begin
        // take one frame byte and copy it into every matching slot
        if (q_valid)
        begin
          bi = q.first ? '0 : idx;
          if (q.first)
          begin
            next_fsrc = q.src;
            next_ferr = 1'b0;
          end
          if (q.err || (!q.first && q.src != fsrc))
            next_ferr = 1'b1;
          if (bi != '1)
            next_idx = bi + 1'b1; // byte count from zero
          for (int i = 0; i < NSLOT; i++)
          begin
            rel = bi - (cfs_pkg::IDX_W+1)'(cfg[i].off);
            if (cfg[i].en && q.src == cfg[i].saddr && bi >= (cfs_pkg::IDX_W+1)'(cfg[i].off)
                && rel < (cfs_pkg::IDX_W+1)'(cfs_pkg::REC_BYTES))
              next_shd[i][(4 - 32'(rel[2:0]))*8 +: 8] = q.data;
          end
          if (q.last)
            next_state = ST_COMMIT;
        end
      end
      ST_COMMIT:
      begin
        // accept a value only from a whole, clean frame that covers it
        next_state = ST_RUN;
        for (int i = 0; i < NSLOT; i++)
        begin
          fend = (cfs_pkg::IDX_W+1)'(cfg[i].off) + (cfs_pkg::IDX_W+1)'(type_len(cfg[i].dtype));
          if (cfg[i].en && !ferr && fsrc == cfg[i].saddr && idx >= fend)
          begin
            next_val[i] = decode(shd[i], cfg[i].dtype, cfg[i].swap);
            next_vld[i] = 1'b1;
            if (cfg[i].dtype == cfs_pkg::T_FWS)
            begin
              next_sts[i] = shd[i][(4 - cfs_pkg::STS_POS)*8 +: 8];
              next_flg[i] = (shd[i][cfs_pkg::QUAL_LSB +: 2] == cfs_pkg::QUAL_BAD)
                || (shd[i][cfs_pkg::QUAL_LSB +: 2] == cfs_pkg::QUAL_UNC);
            end
            else
            begin
              next_sts[i] = 8'h0;
              next_flg[i] = 1'b0;
            end
          end
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  // display walk over enabled slots with label and status alternating
  always_comb
  begin
    logic found;
    logic [3:0] cand;
    found = 1'b0;
    cand = dslot;
    for (int i = 0; i < NSLOT; i++)
      en_mask[i] = cfg[i].en;
    next_tmr = tmr;
    next_alt = alt;
    next_dslot = dslot;
    if (en_mask == '0)
      next_tmr = '0;
    else if (!en_mask[dslot] || tmr == 32'(DWELL - 1))
    begin
      next_tmr = '0;
      next_alt = !alt;
      // move on after the second half, or at once if this slot was disabled
      if (alt || !en_mask[dslot])
      begin
        next_alt = 1'b0;
        for (int k = 1; k <= NSLOT; k++)
        begin
          cand = 4'((32'(dslot) + k) % NSLOT);
          if (!found && en_mask[cand])
          begin
            found = 1'b1;
            next_dslot = cand;
          end
        end
      end
    end
    else
      next_tmr = tmr + 32'h1;
  end

  // state registers
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state <= ST_RUN;
      idx <= '0;
      fsrc <= 7'h0;
      ferr <= 1'b1;
      vld <= '0;
      flg <= '0;
      rdata <= 32'h0;
      dslot <= 4'h0;
      tmr <= 32'h0;
      alt <= 1'b0;
      for (int i = 0; i < NSLOT; i++)
      begin
        cfg[i] <= '0;
        val[i] <= 32'h0;
        sts[i] <= 8'h0;
        shd[i] <= 40'h0;
      end
    end
    else
    begin
      state <= next_state;
      idx <= next_idx;
      fsrc <= next_fsrc;
      ferr <= next_ferr;
      vld <= next_vld;
      flg <= next_flg;
      rdata <= next_rdata;
      dslot <= next_dslot;
      tmr <= next_tmr;
      alt <= next_alt;
      for (int i = 0; i < NSLOT; i++)
      begin
        cfg[i] <= next_cfg[i];
        val[i] <= next_val[i];
        sts[i] <= next_sts[i];
        shd[i] <= next_shd[i];
      end
    end
  end

  // output flops; the bus driver stays released at all times
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      REG_RDATA <= 32'h0;
      BUS_TX_OE_N <= 1'b1;
      DISP_SLOT <= 4'h0;
      DISP_VALUE <= 32'h0;
      DISP_TYPE <= cfs_pkg::T_FWS;
      DISP_STATUS <= 8'h0;
      DISP_VALID <= 1'b0;
      DISP_STATUS_ON <= 1'b0;
      DISP_NONE <= 1'b1;
    end
    else
    begin
      REG_RDATA <= next_rdata;
      BUS_TX_OE_N <= 1'b1; // listen only, receiver at fixed rate
      DISP_SLOT <= next_dslot;
      DISP_VALUE <= next_val[next_dslot];
      DISP_TYPE <= next_cfg[next_dslot].dtype;
      DISP_STATUS <= next_sts[next_dslot];
      DISP_VALID <= next_vld[next_dslot] && next_cfg[next_dslot].en;
      DISP_STATUS_ON <= next_alt && next_flg[next_dslot];
      DISP_NONE <= (en_mask == '0);
    end
  end
endmodule // cfs_sniffer

`default_nettype wire

// [dv/cfs_properties.sv]
// port checker for the sniffer top
// assumes it is bound onto every cfs_sniffer instance
`timescale 1ns/1ps
`default_nettype none
module cfs_chk #(
  parameter int NSLOT = 10
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [cfs_pkg::RA_W-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic BUS_TX_OE_N,
  input wire logic [3:0] DISP_SLOT,
  input wire cfs_pkg::cfs_type_e DISP_TYPE,
  input wire logic [7:0] DISP_STATUS,
  input wire logic DISP_VALID,
  input wire logic DISP_STATUS_ON,
  input wire logic DISP_NONE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // listener only: transmitter stays off
  property p_tx_off; BUS_TX_OE_N; endproperty
  a_tx_off: assert property (p_tx_off) else $error("transmitter enabled");
  // misaligned or bank 3 reads give zero
  property p_rd_bad;
    REG_RD && (REG_ADDR[1:0] != 2'h0 || REG_ADDR[7:6] == 2'h3) |=> REG_RDATA == 32'h0;
  endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("bad address read nonzero");
  // slot index beyond the last slot reads zero
  property p_rd_slot; REG_RD && REG_ADDR[5:2] >= NSLOT |=> REG_RDATA == 32'h0; endproperty
  a_rd_slot: assert property (p_rd_slot) else $error("missing slot read nonzero");
  // slot 0 config bits 18:0 read back what was written
  property p_cfg_rb;
    REG_WR && REG_ADDR == 8'h00 ##2 REG_RD && REG_ADDR == 8'h00 && !$past(REG_WR)
      |=> REG_RDATA[18:0] == $past(REG_WDATA[18:0], 3);
  endproperty
  a_cfg_rb: assert property (p_cfg_rb) else $error("config readback wrong");
  // no enabled slot: nothing valid on display
  property p_none; DISP_NONE |-> !DISP_VALID && !DISP_STATUS_ON; endproperty
  a_none: assert property (p_none) else $error("display active with no slot");
  // shown slot is one of the slots
  property p_slot; !DISP_NONE |-> DISP_SLOT < NSLOT; endproperty
  a_slot: assert property (p_slot) else $error("slot out of range");
  // status byte exists only for float with status
  property p_sts;
    DISP_TYPE != cfs_pkg::T_FWS |-> DISP_STATUS == 8'h00 && !DISP_STATUS_ON;
  endproperty
  a_sts: assert property (p_sts) else $error("status on non-record type");
  // status shown only when bad or uncertain
  property p_flag; DISP_STATUS_ON |-> DISP_VALID && DISP_STATUS[7:6] <= 2'h1; endproperty
  a_flag: assert property (p_flag) else $error("status shown while good");
  c_flag: cover property (DISP_STATUS_ON);
  c_valid: cover property (DISP_VALID && DISP_SLOT == 4'h1);
  c_none: cover property ($rose(DISP_NONE));
endmodule // cfs_chk
bind cfs_sniffer cfs_chk #(.NSLOT(NSLOT)) cfs_chk_inst (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .BUS_TX_OE_N(BUS_TX_OE_N),
  .DISP_SLOT(DISP_SLOT), .DISP_TYPE(DISP_TYPE), .DISP_STATUS(DISP_STATUS),
  .DISP_VALID(DISP_VALID), .DISP_STATUS_ON(DISP_STATUS_ON), .DISP_NONE(DISP_NONE)
);
`default_nettype wire

// [dv/cfs_frame_src.sv]
// far side: slaves' cyclic frames as the receiver hands them on
// assumes the valid/ready byte handshake on clk
`timescale 1ns/1ps
`default_nettype none
module cfs_frame_src (
  input wire logic clk,
  output var logic valid,
  output var cfs_pkg::cfs_rx_s rx,
  input wire logic ready
);
  initial
  begin
    valid = 1'b0;
    rx = '0;
  end
  // one frame, each byte held until it is taken
  task automatic send(input logic [6:0] s, input logic [7:0] b [], input logic e);
    for (int k = 0; k < b.size(); k++)
    begin
      valid <= 1'b1;
      rx <= '{k == 0, k == b.size() - 1, e, s, b[k]};
      @(posedge clk iff ready);
    end
    valid <= 1'b0;
    // released lines show no stale byte
    rx <= ~rx;
  endtask
endmodule // cfs_frame_src
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench: registers, frame capture, display
// assumes cfs_pkg, the frame source model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {
    cfs_pkg::cfs_cfg_s cfg;
    logic [31:0] val;
    logic [31:0] sts;
  } cfs_row_s;
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic RX_VALID;
  cfs_pkg::cfs_rx_s RX_BYTE;
  logic [31:0] REG_RDATA, DISP_VALUE;
  logic RX_READY, BUS_TX_OE_N, DISP_VALID, DISP_STATUS_ON, DISP_NONE;
  logic [3:0] DISP_SLOT;
  cfs_pkg::cfs_type_e DISP_TYPE;
  logic [7:0] DISP_STATUS;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  cfs_row_s rows [10];
  logic [7:0] frm [];
  logic seen;
  logic [31:0] shown_val = 32'h0; // value seen on the display for slot 1
  logic [2:0] shown_type = 3'h7; // type seen on the display for slot 1
  cfs_sniffer #(.DWELL(20)) cfs_sniffer_inst (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RX_VALID(RX_VALID),
    .RX_BYTE(RX_BYTE), .RX_READY(RX_READY), .BUS_TX_OE_N(BUS_TX_OE_N),
    .DISP_SLOT(DISP_SLOT), .DISP_VALUE(DISP_VALUE), .DISP_TYPE(DISP_TYPE),
    .DISP_STATUS(DISP_STATUS), .DISP_VALID(DISP_VALID),
    .DISP_STATUS_ON(DISP_STATUS_ON), .DISP_NONE(DISP_NONE)
  );
  cfs_frame_src cfs_frame_src_inst (
    .clk(SYS_CLK), .valid(RX_VALID), .rx(RX_BYTE), .ready(RX_READY)
  );
  // enabled config listening to slave 5
  function automatic cfs_pkg::cfs_cfg_s mk(input logic [2:0] t, input logic [7:0] o,
    input logic [1:0] s);
    mk = '{cfs_pkg::cfs_swap_e'(s), 1'b1, cfs_pkg::cfs_type_e'(t), 7'h05, o};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  // read, data taken in the cycle after the strobe
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
    chk(nm, e, d);
    @(posedge SYS_CLK);
  endtask
  task automatic send(input logic [6:0] s, input logic e);
    cfs_frame_src_inst.send(s, frm, e);
    repeat (8) @(posedge SYS_CLK);
  endtask
  task automatic final_report();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  // hang guard
  always @(posedge SYS_CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      final_report();
    end
  end
  initial
  begin
    rows = '{'{mk(3'h0, 8'h00, 2'h0), 32'h41200000, 32'h180},
      '{mk(3'h0, 8'h05, 2'h0), 32'hc2480000, 32'h31f},
      '{mk(3'h1, 8'h01, 2'h0), 32'h20000080, 32'h100},
      '{mk(3'h2, 8'h00, 2'h0), 32'h41, 32'h100},
      '{mk(3'h3, 8'h04, 2'h0), 32'h80c2, 32'h100},
      '{mk(3'h5, 8'h04, 2'h0), 32'hffffff80, 32'h100},
      '{mk(3'h6, 8'h05, 2'h0), 32'hffffc248, 32'h100},
      '{mk(3'h4, 8'h05, 2'h1), 32'h48c2, 32'h100},
      '{mk(3'h7, 8'h06, 2'h2), 32'hf1000084, 32'h100},
      '{mk(3'h3, 8'h09, 2'h0), 32'h0, 32'h0}};
    repeat (8) @(posedge SYS_CLK);
    chk("oe_n", 32'h1, {31'h0, BUS_TX_OE_N});
    chk("none", 32'h1, {31'h0, DISP_NONE});
    RST_N <= 1'b1;
    @(posedge SYS_CLK);
    rchk("cfg_reset", 8'h00, 32'h0);
    foreach (rows[i]) wr(8'(4 * i), 32'(rows[i].cfg));
    wr(8'h00, 32'(rows[0].cfg));
    rchk("cfg_rb", 8'h00, 32'(rows[0].cfg));
    frm = '{8'h41, 8'h20, 8'h00, 8'h00, 8'h80, 8'hc2, 8'h48, 8'h00, 8'h00, 8'h1f};
    send(7'h05, 1'b0);
    // one row per slot: value and status word
    foreach (rows[i])
    begin
      rchk("value", 8'(8'h40 + 4 * i), rows[i].val);
      rchk("status", 8'(8'h80 + 4 * i), rows[i].sts);
    end
    rchk("bank3", 8'hc0, 32'h0);
    rchk("slot10", 8'h28, 32'h0);
    rchk("misalign", 8'h41, 32'h0);
    wr(8'h40, 32'h0);
    rchk("ro_value", 8'h40, 32'h41200000);
    // faulty frame, then a frame from a foreign slave
    frm = '{8'h3f, 8'h80, 8'h00, 8'h00, 8'hc0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    send(7'h05, 1'b1);
    rchk("err_frame", 8'h40, 32'h41200000);
    send(7'h06, 1'b0);
    rchk("other_src", 8'h40, 32'h41200000);
    // short frame: only the one-byte slot fits
    frm = '{8'h3f, 8'h80, 8'h00, 8'h00};
    send(7'h05, 1'b0);
    rchk("short_u8", 8'h4c, 32'h3f);
    rchk("short_flt", 8'h48, 32'h20000080);
    rchk("short_fws", 8'h40, 32'h41200000);
    // bad status of slot 1 must alternate onto the display
    seen = 1'b0;
    repeat (1000)
    begin
      @(negedge SYS_CLK);
      if (DISP_SLOT == 4'h1 && DISP_STATUS_ON === 1'b1)
        seen = 1'b1;
      if (DISP_SLOT == 4'h1 && DISP_VALID === 1'b1)
      begin
        shown_val = DISP_VALUE;
        shown_type = DISP_TYPE;
      end
    end
    chk("status_on", 32'h1, {31'h0, seen});
    chk("disp_value", 32'hc2480000, shown_val);
    chk("disp_type", 32'h0, {29'h0, shown_type});
    chk("rx_ready", 32'h1, {31'h0, RX_READY});
    RST_N <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    @(posedge SYS_CLK);
    rchk("cfg_rst2", 8'h24, 32'h0);
    chk("none2", 32'h1, {31'h0, DISP_NONE});
    final_report();
  end
endmodule // testbench
`default_nettype wire
